// ==== core/ccu_top.sv ====
// Capture/compare unit: two reloadable time bases and sixteen channels
`timescale 1ns/10ps
module ccu_top (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_staggered,
    input wire logic [ccu_pkg::CCU_TIMERS-1:0] i_tmr_run,
    input wire logic [ccu_pkg::CCU_TIMERS-1:0][2:0] i_tmr_src,
    input wire logic [ccu_pkg::CCU_TIMERS-1:0] i_tmr_wr,
    input wire logic [ccu_pkg::CCU_TIMERS-1:0] i_rel_wr,
    input wire logic i_neighbour_ovf,
    input wire logic i_ext_count,
    input wire logic [ccu_pkg::CCU_WIDTH-1:0] i_wdata,
    input wire logic [ccu_pkg::CCU_CHANNELS-1:0] i_cc_wr,
    input wire logic [ccu_pkg::CCU_CHANNELS-1:0][2:0] i_cc_mode,
    input wire logic [ccu_pkg::CCU_CHANNELS-1:0] i_cc_timer_sel,
    input wire logic [ccu_pkg::CCU_CHANNELS-1:0] i_cc_single,
    input wire logic [ccu_pkg::CCU_HALF-1:0] i_cc_double,
    input wire logic [ccu_pkg::CCU_CHANNELS-1:0] i_cc_pin,
    output logic [ccu_pkg::CCU_CHANNELS-1:0] o_cc_pin,
    output logic [ccu_pkg::CCU_CHANNELS-1:0] o_cc_pin_oe,
    output logic [ccu_pkg::CCU_CHANNELS-1:0] o_cc_irq,
    output logic [ccu_pkg::CCU_CHANNELS-1:0][ccu_pkg::CCU_WIDTH-1:0] o_cc_value,
    output logic [ccu_pkg::CCU_TIMERS-1:0][ccu_pkg::CCU_WIDTH-1:0] o_tmr_val,
    output logic [ccu_pkg::CCU_TIMERS-1:0] o_tmr_ovf
);
    import ccu_pkg::*;

    // ============================================================
    // Input synchronisers
    logic [CCU_CHANNELS-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [2:0] ext_q, ext_d;
    logic [CCU_CHANNELS-1:0] pin_s1_d, pin_s2_d, pin_s3_d;

    // Third stage only holds the previous level for edge detection
    always_comb begin
        pin_s1_d = i_cc_pin;
        pin_s2_d = pin_s1_q;
        pin_s3_d = pin_s2_q;
        ext_d = {ext_q[1:0], i_ext_count};
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
            ext_q <= 3'h0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_s3_q <= pin_s3_d;
            ext_q <= ext_d;
        end
    end

    // ============================================================
    // Base tick and prescaler
    logic [2:0] stag_q, stag_d;
    logic [2:0] pre_q, pre_d;
    logic base_tick;

    // Staggered operation trades resolution for an eight-cycle time slot
    always_comb begin
        base_tick = i_staggered ? (stag_q == CCU_STAGGER_LAST) : 1'b1;
        stag_d = i_staggered ? stag_q + 3'h1 : 3'h0;
        pre_d = base_tick ? pre_q + 3'h1 : pre_q;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            stag_q <= 3'h0;
            pre_q <= 3'h0;
        end else begin
            stag_q <= stag_d;
            pre_q <= pre_d;
        end
    end

    // ============================================================
    // Time-base timers
    logic [CCU_TIMERS-1:0][CCU_WIDTH-1:0] tmr_q, tmr_d, rel_q, rel_d;
    logic [CCU_TIMERS-1:0] upd_q, upd_d, ovf_q, ovf_d, tick;
    logic ext_edge;

    // Events that coincide with a software write lose to the write
    always_comb begin
        ext_edge = ext_q[1] & ~ext_q[2];
        for (int t = 0; t < CCU_TIMERS; t++) begin
            unique case (i_tmr_src[t])
                CCU_SRC_DIV1: tick[t] = base_tick;
                CCU_SRC_DIV2: tick[t] = base_tick & pre_q[0];
                CCU_SRC_DIV4: tick[t] = base_tick & (&pre_q[1:0]);
                CCU_SRC_DIV8: tick[t] = base_tick & (&pre_q);
                CCU_SRC_NEIGHBOUR: tick[t] = i_neighbour_ovf;
                CCU_SRC_EXTERNAL: tick[t] = ext_edge;
                default: tick[t] = 1'b0;
            endcase
            tick[t] = tick[t] & i_tmr_run[t];
            tmr_d[t] = tmr_q[t];
            rel_d[t] = i_rel_wr[t] ? i_wdata : rel_q[t];
            upd_d[t] = 1'b0;
            ovf_d[t] = 1'b0;
            if (i_tmr_wr[t]) begin
                tmr_d[t] = i_wdata;
            end else if (tick[t]) begin
                upd_d[t] = 1'b1;
                if (tmr_q[t] == CCU_TMR_MAX) begin
                    tmr_d[t] = rel_q[t];
                    ovf_d[t] = 1'b1;
                end else begin
                    tmr_d[t] = tmr_q[t] + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            tmr_q <= {CCU_TIMERS{CCU_TMR_RESET}};
            rel_q <= {CCU_TIMERS{CCU_REL_RESET}};
            upd_q <= '0;
            ovf_q <= '0;
        end else begin
            tmr_q <= tmr_d;
            rel_q <= rel_d;
            upd_q <= upd_d;
            ovf_q <= ovf_d;
        end
    end

    assign o_tmr_val = tmr_q;
    assign o_tmr_ovf = ovf_q;

    // ============================================================
    // Channel array
    logic [CCU_CHANNELS-1:0] hit, pair_en, pair_hit, ch_pin, ch_irq;
    logic [CCU_CHANNELS-1:0][CCU_WIDTH-1:0] ch_val, sel_val;
    logic [CCU_CHANNELS-1:0] sel_upd, sel_ovf;

    // Channel k and k+8 pair on pin k in double-register operation
    always_comb begin
        for (int c = 0; c < CCU_CHANNELS; c++) begin
            sel_val[c] = tmr_q[i_cc_timer_sel[c]];
            sel_upd[c] = upd_q[i_cc_timer_sel[c]];
            sel_ovf[c] = ovf_q[i_cc_timer_sel[c]];
            // Modulo indexing keeps the untaken branch inside the vector range
            if (c < CCU_HALF) begin
                pair_en[c] = i_cc_double[c % CCU_HALF];
                pair_hit[c] = hit[(c + CCU_HALF) % CCU_CHANNELS];
            end else begin
                pair_en[c] = 1'b0;
                pair_hit[c] = 1'b0;
            end
        end
    end

    for (genvar g = 0; g < CCU_CHANNELS; g++) begin : g_chan
        ccu_chan u_chan (
            .i_clk_sys(i_clk_sys),
            .i_resetn(i_resetn),
            .i_mode(i_cc_mode[g]),
            .i_single(i_cc_single[g]),
            .i_wr(i_cc_wr[g]),
            .i_wdata(i_wdata),
            .i_tmr_val(sel_val[g]),
            .i_tmr_upd(sel_upd[g]),
            .i_tmr_ovf(sel_ovf[g]),
            .i_pin_now(pin_s2_q[g]),
            .i_pin_prev(pin_s3_q[g]),
            .i_pair_en(pair_en[g]),
            .i_pair_hit(pair_hit[g]),
            .o_hit(hit[g]),
            .o_value(ch_val[g]),
            .o_pin(ch_pin[g]),
            .o_irq(ch_irq[g])
        );
    end

    // ============================================================
    // Pin drive enables
    logic [CCU_CHANNELS-1:0] oe_q, oe_d;

    // A channel drives its pin in a pin-moving compare mode; in double-register operation channels 0 to 7 also drive and channels 8 to 15 do not
    always_comb begin
        for (int c = 0; c < CCU_CHANNELS; c++) begin
            oe_d[c] = (i_cc_mode[c] == CCU_MODE_CMP1) | (i_cc_mode[c] == CCU_MODE_CMP3);
            if (c < CCU_HALF) begin
                oe_d[c] = oe_d[c] | i_cc_double[c % CCU_HALF];
            end else begin
                oe_d[c] = oe_d[c] & ~i_cc_double[c % CCU_HALF];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            oe_q <= '0;
        end else begin
            oe_q <= oe_d;
        end
    end

    assign o_cc_pin = ch_pin;
    assign o_cc_pin_oe = oe_q;
    assign o_cc_irq = ch_irq;
    assign o_cc_value = ch_val;
endmodule

// ==== core/ccu_pkg.sv ====
// Constants shared by the capture/compare unit and its channel slices
package ccu_pkg;
    // ============================================================
    // Array geometry
    localparam int CCU_CHANNELS = 16;
    localparam int CCU_HALF = 8;
    localparam int CCU_TIMERS = 2;
    localparam int CCU_WIDTH = 16;

    // ============================================================
    // Channel mode encodings
    localparam logic [2:0] CCU_MODE_OFF = 3'h0;
    localparam logic [2:0] CCU_MODE_CAP_RISE = 3'h1;
    localparam logic [2:0] CCU_MODE_CAP_FALL = 3'h2;
    localparam logic [2:0] CCU_MODE_CAP_BOTH = 3'h3;
    localparam logic [2:0] CCU_MODE_CMP0 = 3'h4;
    localparam logic [2:0] CCU_MODE_CMP1 = 3'h5;
    localparam logic [2:0] CCU_MODE_CMP2 = 3'h6;
    localparam logic [2:0] CCU_MODE_CMP3 = 3'h7;
    localparam int CCU_MODE_CMP_BIT = 2;

    // ============================================================
    // Timer count clock selections
    localparam logic [2:0] CCU_SRC_DIV1 = 3'h0;
    localparam logic [2:0] CCU_SRC_DIV2 = 3'h1;
    localparam logic [2:0] CCU_SRC_DIV4 = 3'h2;
    localparam logic [2:0] CCU_SRC_DIV8 = 3'h3;
    localparam logic [2:0] CCU_SRC_NEIGHBOUR = 3'h4;
    localparam logic [2:0] CCU_SRC_EXTERNAL = 3'h5;

    // ============================================================
    // Timing and reset values
    localparam logic [2:0] CCU_STAGGER_LAST = 3'h7;
    localparam logic [15:0] CCU_TMR_MAX = 16'hFFFF;
    localparam logic [15:0] CCU_TMR_RESET = 16'h0000;
    localparam logic [15:0] CCU_REL_RESET = 16'h0000;
    localparam logic [15:0] CCU_VAL_RESET = 16'h0000;
endpackage

// ==== core/ccu_chan.sv ====
// One dual-purpose capture/compare register slice with its pin logic
`timescale 1ns/10ps
module ccu_chan (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [2:0] i_mode,
    input wire logic i_single,
    input wire logic i_wr,
    input wire logic [ccu_pkg::CCU_WIDTH-1:0] i_wdata,
    input wire logic [ccu_pkg::CCU_WIDTH-1:0] i_tmr_val,
    input wire logic i_tmr_upd,
    input wire logic i_tmr_ovf,
    input wire logic i_pin_now,
    input wire logic i_pin_prev,
    input wire logic i_pair_en,
    input wire logic i_pair_hit,
    output logic o_hit,
    output logic [ccu_pkg::CCU_WIDTH-1:0] o_value,
    output logic o_pin,
    output logic o_irq
);
    import ccu_pkg::*;

    logic [CCU_WIDTH-1:0] val_q, val_d;
    logic pin_q, pin_d;
    logic irq_q, irq_d;
    logic fired_q, fired_d;
    logic done_q, done_d;
    logic edge_r, edge_f, cap_ev, is_cmp, once_mode, hit;

    // ============================================================
    // Event decode
    always_comb begin
        edge_r = i_pin_now & ~i_pin_prev;
        edge_f = ~i_pin_now & i_pin_prev;
        cap_ev = ((i_mode == CCU_MODE_CAP_RISE) & edge_r)
               | ((i_mode == CCU_MODE_CAP_FALL) & edge_f)
               | ((i_mode == CCU_MODE_CAP_BOTH) & (edge_r | edge_f));
        is_cmp = i_mode[CCU_MODE_CMP_BIT];
        once_mode = (i_mode == CCU_MODE_CMP2) | (i_mode == CCU_MODE_CMP3);
        // Match only on a fresh timer value, so a stalled timer fires once
        hit = is_cmp & i_tmr_upd & (i_tmr_val == val_q)
            & ~(i_single & fired_q)
            & ~(once_mode & done_q);
    end

    // ============================================================
    // Next-state logic
    always_comb begin
        val_d = val_q;
        if (cap_ev) begin
            val_d = i_tmr_val;
        end else if (i_wr) begin
            val_d = i_wdata;
        end
        // Set wins over clear in both event latches
        fired_d = hit | (fired_q & ~i_wr);
        done_d = hit | (done_q & ~i_tmr_ovf);
        irq_d = cap_ev | (hit & ((i_mode == CCU_MODE_CMP0) | (i_mode == CCU_MODE_CMP2)));
        pin_d = pin_q;
        if ((i_mode == CCU_MODE_CMP1) && hit) begin
            pin_d = ~pin_d;
        end
        if (i_pair_en && i_pair_hit) begin
            pin_d = ~pin_d;
        end
        if (i_mode == CCU_MODE_CMP3) begin
            if (hit) begin
                pin_d = 1'b1;
            end else if (i_tmr_ovf) begin
                pin_d = 1'b0;
            end
        end
    end

    // ============================================================
    // State registers
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            val_q <= CCU_VAL_RESET;
            pin_q <= 1'b0;
            irq_q <= 1'b0;
            fired_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            val_q <= val_d;
            pin_q <= pin_d;
            irq_q <= irq_d;
            fired_q <= fired_d;
            done_q <= done_d;
        end
    end

    assign o_hit = hit;
    assign o_value = val_q;
    assign o_pin = pin_q;
    assign o_irq = irq_q;
endmodule

// ==== bench/ccu_monitor.sv ====
// Checker watching the ports of the capture/compare unit
`timescale 1ns/10ps
module ccu_monitor (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_staggered,
    input wire logic [1:0] i_tmr_run,
    input wire logic [1:0][2:0] i_tmr_src,
    input wire logic [1:0] i_tmr_wr,
    input wire logic [15:0][2:0] i_cc_mode,
    input wire logic [15:0] i_cc_timer_sel,
    input wire logic [15:0] i_cc_single,
    input wire logic [7:0] i_cc_double,
    input wire logic [15:0] i_cc_pin,
    input wire logic [15:0] o_cc_pin,
    input wire logic [15:0] o_cc_irq,
    input wire logic [15:0][15:0] o_cc_value,
    input wire logic [1:0][15:0] o_tmr_val,
    input wire logic [1:0] o_tmr_ovf
);
    import ccu_pkg::*;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    // Timer a is the time base the bench keeps on the watched channels
    wire logic [15:0] t0 = o_tmr_val[0];
    // ============================================================
    // Time base
    chk_tmr_reload: assert property (o_tmr_ovf[0] |-> $past(t0) == CCU_TMR_MAX)
        else $error("overflow without terminal count");
    chk_tmr_step: assert property ($past(i_resetn) && i_tmr_run[0] && !i_staggered
        && !$past(i_staggered) && i_tmr_src[0] == CCU_SRC_DIV1 && !i_tmr_wr[0]
        && t0 != CCU_TMR_MAX |=> t0 == $past(t0) + 16'h1) else $error("timer missed a tick");
    chk_stagger_hold: assert property (i_staggered && $past(i_staggered) && $changed(t0)
        && !$past(i_tmr_wr[0]) && i_tmr_src[0] <= CCU_SRC_DIV8
        |=> (!i_staggered || $past(i_tmr_wr[0]) || $stable(t0))[*6])
        else $error("staggered timer moved too soon");
    // ============================================================
    // Capture
    chk_cap_latch: assert property (i_cc_mode[0] == CCU_MODE_CAP_RISE && $rose(i_cc_pin[0])
        && !i_cc_timer_sel[0] |-> ##3 o_cc_irq[0] && o_cc_value[0] == $past(t0))
        else $error("capture value or request wrong");
    chk_cap_edge: assert property (i_cc_mode[1] == CCU_MODE_CAP_FALL && $changed(i_cc_pin[1])
        |-> ##3 o_cc_irq[1] == !$past(i_cc_pin[1], 3)) else $error("capture edge wrong");
    // ============================================================
    // Compare; a match counts only on a fresh timer value, not after a write
    chk_cmp_toggle: assert property (i_cc_mode[2] == CCU_MODE_CMP1 && !i_cc_single[2]
        && !i_cc_double[2] && !i_cc_timer_sel[2] && $changed(t0) && !$past(i_tmr_wr[0])
        && t0 == o_cc_value[2] |=> o_cc_pin[2] != $past(o_cc_pin[2]))
        else $error("pin did not toggle on match");
    chk_cmp_irq: assert property (i_cc_mode[0] == CCU_MODE_CMP0 && !i_cc_single[0]
        && !i_cc_timer_sel[0] && $changed(t0) && !$past(i_tmr_wr[0])
        && t0 == o_cc_value[0] |=> o_cc_irq[0]) else $error("no request on match");
    chk_set_clear: assert property (i_cc_mode[6] == CCU_MODE_CMP3 && !i_cc_double[6]
        && !i_cc_timer_sel[6] && o_tmr_ovf[0] && t0 != o_cc_value[6] |=> !o_cc_pin[6])
        else $error("pin not cleared on overflow");
endmodule
bind ccu_top ccu_monitor ccu_monitor_i (.i_clk_sys, .i_resetn, .i_staggered, .i_tmr_run,
    .i_tmr_src, .i_tmr_wr, .i_cc_mode, .i_cc_timer_sel, .i_cc_single, .i_cc_double,
    .i_cc_pin, .o_cc_pin, .o_cc_irq, .o_cc_value, .o_tmr_val, .o_tmr_ovf);

// ==== bench/ccu_far_end.sv ====
// Far-side model: channel pads and the external count source
`timescale 1ns/10ps
module ccu_far_end (
    input wire logic i_clk_sys,
    input wire logic i_ext_en,
    input wire logic [15:0] i_lvl,
    input wire logic [15:0] i_drv,
    input wire logic [15:0] i_oe,
    output logic [15:0] o_pad,
    output logic o_ext
);
    logic [2:0] div_q = 3'h0;
    // Pad level: the channel wins while it drives, else the outside source
    assign o_pad = (i_oe & i_drv) | (~i_oe & i_lvl);
    // Slow square wave, parked low outside bursts so no stray edge is counted
    always_ff @(posedge i_clk_sys) begin
        div_q <= i_ext_en ? div_q + 3'h1 : 3'h0;
    end
    assign o_ext = div_q[2];
endmodule

// ==== bench/test_ccu_top.sv ====
// Self-checking bench for the capture/compare unit
`timescale 1ns/10ps
module test_ccu_top;
    import ccu_pkg::*;
    logic i_clk_sys = 1'h0;
    logic i_resetn = 1'h0;
    logic i_staggered = 1'h0;
    logic i_neighbour_ovf = 1'h0;
    logic ext_en = 1'h0;
    logic [1:0] i_tmr_run = '0, i_tmr_wr = '0, i_rel_wr = '0;
    logic [1:0][2:0] i_tmr_src = '0;
    logic [15:0] i_wdata = '0, i_cc_wr = '0, i_cc_timer_sel = '0, i_cc_single = '0, lvl = '0;
    logic [15:0][2:0] i_cc_mode = '0;
    logic [7:0] i_cc_double = '0;
    logic [15:0] w;
    logic [2:0] md;
    wire logic i_ext_count;
    wire logic [15:0] i_cc_pin, o_cc_pin, o_cc_pin_oe, o_cc_irq;
    wire logic [15:0][15:0] o_cc_value;
    wire logic [1:0][15:0] o_tmr_val;
    wire logic [1:0] o_tmr_ovf;
    int n_mismatch = 0, compares = 0, seed = 32'h0F78, cyc = 0, n_ext = 0, i, k, ch, p, q;
    // ============================================================
    // Clock, edge count and count-input rises seen on the wire
    always #12.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) cyc <= cyc + 1;
    always @(posedge i_ext_count) n_ext++;
    ccu_top ccu_top_i (.i_clk_sys, .i_resetn, .i_staggered, .i_tmr_run, .i_tmr_src, .i_tmr_wr,
        .i_rel_wr, .i_neighbour_ovf, .i_ext_count, .i_wdata, .i_cc_wr, .i_cc_mode,
        .i_cc_timer_sel, .i_cc_single, .i_cc_double, .i_cc_pin, .o_cc_pin, .o_cc_pin_oe,
        .o_cc_irq, .o_cc_value, .o_tmr_val, .o_tmr_ovf);
    ccu_far_end ccu_far_end_i (.i_clk_sys, .i_ext_en(ext_en), .i_lvl(lvl), .i_drv(o_cc_pin),
        .i_oe(o_cc_pin_oe), .o_pad(i_cc_pin), .o_ext(i_ext_count));
    // ============================================================
    // Shared tasks; inputs they drive move 1 ns after the rising edge, the far-end outputs move on it
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Strobes drop a full cycle before they may rise again
    task automatic wr_tmr(input logic [1:0] m, input logic rel, input logic [15:0] v);
        i_wdata = v;
        if (rel) i_rel_wr = m;
        else i_tmr_wr = m;
        tick(1);
        i_rel_wr = '0;
        i_tmr_wr = '0;
        tick(1);
    endtask
    task automatic wr_cc(input int c, input logic [15:0] v);
        i_wdata = v;
        i_cc_wr[c] = 1'h1;
        tick(1);
        i_cc_wr = '0;
        tick(1);
    endtask
    task automatic wait_irq(input int c);
        int t;
        for (t = 0; t < 100 && o_cc_irq[c] !== 1'h1; t++) tick(1);
        if (t == 100) begin
            n_mismatch++;
            report_and_stop;
        end
    endtask
    function automatic logic trig(input logic [2:0] m, input logic lv);
        return m == CCU_MODE_CAP_BOTH || (m == CCU_MODE_CAP_RISE && lv)
            || (m == CCU_MODE_CAP_FALL && !lv);
    endfunction
    // Timer parked at its reload value while the channel is set up, so no match
    // slips in early; 193 samples see updates up to the third overflow only
    task automatic run_cmp(input int c, input logic [2:0] m, input logic s, input logic d);
        int t, ni, np;
        logic old;
        i_cc_mode[c] = m;
        i_cc_single[c] = s;
        i_cc_double[c] = d;
        i_tmr_run[0] = 1'h0;
        wr_tmr(2'h1, 1'h0, 16'hFFC0);
        if (d) i_cc_mode[c + 8] = CCU_MODE_CMP0;
        if (d) wr_cc(c + 8, 16'hFFE0);
        wr_cc(c, 16'hFFC1 + 16'($random(seed) & 32'h1E));
        i_tmr_run[0] = 1'h1;
        ni = 0;
        np = 0;
        old = o_cc_pin[c];
        for (t = 0; t < 193; t++) begin
            tick(1);
            ni += (o_cc_irq[c] === 1'h1);
            np += (o_cc_pin[c] !== old);
            old = o_cc_pin[c];
        end
        k = s ? 1 : 3;
        cmp16(16'(ni), (m == CCU_MODE_CMP0 || m == CCU_MODE_CMP2) ? 16'(k) : 16'h0);
        cmp16(16'(np), 16'(m == CCU_MODE_CMP1 ? k : m == CCU_MODE_CMP3 ? 2 * k : 0)
            + 16'(d ? 3 : 0));
        cmp16(16'(o_cc_pin_oe[c]), 16'(m[0] | d));
        i_cc_mode[c] = CCU_MODE_OFF;
        i_cc_mode[c + 8] = CCU_MODE_OFF;
        i_cc_double = '0;
        i_cc_single = '0;
        tick(2);
    endtask
    // ============================================================
    // Main sequence: capture, count sources, staggering, compare modes
    initial begin
        repeat (8) @(posedge i_clk_sys);
        #1;
        i_resetn = 1'h1;
        tick(1);
        i_tmr_run = 2'h3;
        w = 16'($random(seed) & 32'h7FFF);
        q = cyc;
        wr_tmr(2'h3, 1'h0, w);
        for (i = 0; i < 16; i++) begin
            ch = i < 4 ? i / 2 : $unsigned($random(seed)) % 16;
            md = i < 2 ? CCU_MODE_CAP_RISE : i < 4 ? CCU_MODE_CAP_FALL
                : 3'(1 + $unsigned($random(seed)) % 3);
            i_cc_mode[ch] = md;
            i_cc_timer_sel[ch] = i < 4 ? 1'h0 : 1'($random(seed));
            tick(2);
            lvl[ch] = ~lvl[ch];
            p = cyc;
            k = 0;
            repeat (8) begin
                tick(1);
                k |= (o_cc_irq[ch] === 1'h1);
            end
            cmp16(16'(k), 16'(trig(md, lvl[ch])));
            if (trig(md, lvl[ch])) cmp16(o_cc_value[ch], w + 16'(p - q + 1));
        end
        i_cc_mode = '0;
        i_cc_timer_sel = '0;
        i_tmr_src[1] = CCU_SRC_NEIGHBOUR;
        wr_tmr(2'h2, 1'h0, 16'h0);
        k = 1 + $unsigned($random(seed)) % 8;
        repeat (k + 1) begin
            i_tmr_run[1] = o_tmr_val[1] < 16'(k);
            i_neighbour_ovf = 1'h1;
            tick(1);
            i_neighbour_ovf = 1'h0;
            tick(1);
        end
        cmp16(o_tmr_val[1], 16'(k));
        i_tmr_run[1] = 1'h1;
        i_tmr_src[1] = CCU_SRC_EXTERNAL;
        wr_tmr(2'h2, 1'h0, 16'h0);
        n_ext = 0;
        ext_en = 1'h1;
        tick(60);
        ext_en = 1'h0;
        tick(6);
        cmp16(o_tmr_val[1], 16'(n_ext));
        i_staggered = 1'h1;
        tick(80);
        i_staggered = 1'h0;
        wr_tmr(2'h1, 1'h1, 16'hFFC0);
        wr_tmr(2'h1, 1'h0, 16'hFFC0);
        for (i = 0; i < 8; i++) run_cmp(i, 3'(4 + i / 2), 1'(i), 1'h0);
        run_cmp(0, CCU_MODE_CMP1, 1'h0, 1'h1);
        // A later match in the same period: repeats in mode 0, refused in mode 2
        for (i = 0; i < 2; i++) begin
            i_cc_mode[2] = i ? CCU_MODE_CMP2 : CCU_MODE_CMP0;
            wr_cc(2, 16'hFFD0);
            wait_irq(2);
            wr_cc(2, 16'hFFE0);
            k = 0;
            repeat (24) begin
                tick(1);
                k += (o_cc_irq[2] === 1'h1);
            end
            cmp16(16'(k), 16'(1 - i));
        end
        report_and_stop;
    end
endmodule
